// [src/sfl_consts.svh]
// Constants for the synthesizer function/initialization latch control.
// Assumes a 24-bit serial word, control bits in the two lowest positions.
//
// Behaviour
// [R1] Control code 10 loads the function latch
// [R2] Counter reset bit holds R and AB counters
// [R3] Release of counter reset restarts counters aligned
// [R4] Low chip enable powers down at once
// [R5] Power-down bit with async mode: immediate
// [R6] Sync mode waits for next charge pump event
// [R7] Power-down loads counters, tristates pump, resets lock
// [R8] Serial loading continues during power-down
// [R9] Fastlock only when its enable bit set
// [R10] Mode bit picks fastlock mode 1 or 2
// [R11] Mode 1: gain bit follows host writes
// [R12] Mode 2: gain bit self-clears after timeout
// [R13] Timeout counter runs only in mode 2
// [R14] Low current bits primary, upper bits secondary
// [R15] Host keeps prescaler output at most 300 MHz
// [R16] Three-state bit floats the charge pump
// [R17] Code 11 loads function latch, fires reset pulse
// [R18] Init pulse also triggers programmed sync power-down
// [R19] First AB load after init refires pulse
// [R20] Host order: init, function, R, AB
// [R21] Host order under low chip enable
// [R22] Latched settings survive chip-enable cycles
// [R23] Shift on rising clock, transfer on strobe
// [R24] Timeout counts phase detector cycles, clears gain
`ifndef SFL_CONSTS_SVH
`define SFL_CONSTS_SVH

`define SFL_WORD_W        24
`define SFL_SEL_R         2'h0
`define SFL_SEL_AB        2'h1
`define SFL_SEL_FUNC      2'h2
`define SFL_SEL_INIT      2'h3
`define SFL_CNT_RST_POS   2
`define SFL_PD_REQ_POS    3
`define SFL_PD_POL_POS    7
`define SFL_CP_TRI_POS    8
`define SFL_FL_EN_POS     9
`define SFL_FL_MODE_POS   10
`define SFL_TMO_LSB       11
`define SFL_CUR1_LSB      15
`define SFL_CUR2_LSB      18
`define SFL_PD_SYNC_POS   21
`define SFL_AB_GAIN_POS   21
`define SFL_TMO_STEP      4
`define SFL_TMO_BASE      3
`define SFL_FUNC_RESET    24'h000000

`endif

// [src/sfl_pkg.sv]
// Types for the synthesizer latch control block.
// Assumes sfl_consts.svh is available on the include path.
package sfl_pkg;

    typedef struct packed {
        logic       tristate;
        logic       lock_det_reset;
        logic       counter_hold;
        logic       tmo_load;
        logic [2:0] current;
        logic       fastlock;
    } sfl_cp_ctl_s;

    typedef struct packed {
        logic        r_load;
        logic        ab_load;
        logic [23:0] word;
    } sfl_load_s;

endpackage

// [src/sfl_ctrl.sv]
// Function/initialization latch control of a frequency synthesizer.
// Assumes a serial host on its own clock, and same-clock pulses from
// the phase detector for charge pump events and comparison cycles.
`timescale 1ns/1ps
`include "sfl_consts.svh"

module sfl_ctrl
    import sfl_pkg::*;
#(
    parameter int TMO_W = 6
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        link_clk,
    input  wire logic        ser_data,
    input  wire logic        latch_load_strobe,
    input  wire logic        chip_enable,
    input  wire logic        cp_event,
    input  wire logic        pd_cycle,
    output logic [23:0]      func_word,
    output logic             powerdown,
    output logic             init_pulse,
    output sfl_cp_ctl_s      cp_ctl,
    output sfl_load_s        load_out
);

    // ************************************************************
    // Link domain: serial shifter
    // ************************************************************
    typedef struct packed {
        logic [23:0] shift;
    } sfl_link_s;

    sfl_link_s lk_r;
    sfl_link_s lk_nxt;

    always_comb begin
        lk_nxt = lk_r;
        lk_nxt.shift = {lk_r.shift[22:0], ser_data}; // [R23] [R8]
    end

    // No reset: only data lives here, and the host stops the clock
    // while the strobe is high, so the word is still at transfer.
    always_ff @(posedge link_clk) begin
        lk_r <= lk_nxt;
    end

    // ************************************************************
    // Main domain state
    // ************************************************************
    typedef struct packed {
        logic              ce_s1;
        logic              ce_s2;
        logic              stb_s1;
        logic              stb_s2;
        logic              stb_s3;
        logic [23:0]       func;
        logic              gain;
        logic              init_armed;
        logic              sync_pd;
        logic [TMO_W-1:0]  tmo_cnt;
        logic [23:0]       func_o;
        logic              pd_o;
        logic              init_o;
        sfl_cp_ctl_s       cp_o;
        sfl_load_s         ld_o;
    } sfl_state_s;

    sfl_state_s st_r;
    sfl_state_s st_nxt;

    function automatic logic [TMO_W-1:0] tmo_cycles(input logic [3:0] c);
        logic [TMO_W+1:0] v;
        v = {{(TMO_W-2){1'b0}}, c} * (TMO_W+2)'(`SFL_TMO_STEP)
            + (TMO_W+2)'(`SFL_TMO_BASE);
        return v[TMO_W-1:0];
    endfunction

    logic       stb_rise;
    logic [1:0] sel;
    logic       ld_func;
    logic       ld_init;
    logic       ld_ab;
    logic       pulse;
    logic       pd_req;
    logic       pd_sel;
    logic       pd_now;
    logic       fl_en;
    logic       mode2;
    logic       expire;
    logic [23:0] f;

    always_comb begin
        st_nxt = st_r;
        f = st_r.func;
        st_nxt.ce_s1 = chip_enable;
        st_nxt.ce_s2 = st_r.ce_s1;
        st_nxt.stb_s1 = latch_load_strobe;
        st_nxt.stb_s2 = st_r.stb_s1;
        st_nxt.stb_s3 = st_r.stb_s2;
        stb_rise = st_r.stb_s2 & ~st_r.stb_s3;
        sel = lk_r.shift[1:0];
        // Loads are accepted in every power state
        ld_func = stb_rise & (sel == `SFL_SEL_FUNC);  // [R1] [R8]
        ld_init = stb_rise & (sel == `SFL_SEL_INIT);  // [R17]
        ld_ab   = stb_rise & (sel == `SFL_SEL_AB);
        if (ld_func | ld_init) begin
            st_nxt.func = lk_r.shift;                 // [R1] [R17]
            f = lk_r.shift;
        end
        st_nxt.ld_o.r_load  = stb_rise & (sel == `SFL_SEL_R);
        st_nxt.ld_o.ab_load = ld_ab;
        st_nxt.ld_o.word    = stb_rise ? lk_r.shift : st_r.ld_o.word;

        // Init pulse, and once more on the first AB load after it
        pulse = ld_init | (ld_ab & st_r.init_armed);  // [R17] [R19]
        if (ld_init) begin
            st_nxt.init_armed = 1'b1;                 // [R19]
        end else if (ld_ab) begin
            st_nxt.init_armed = 1'b0;                 // [R19]
        end

        // Power-down
        pd_req = f[`SFL_PD_REQ_POS];
        pd_sel = f[`SFL_PD_SYNC_POS];
        if (!(pd_req & pd_sel) | ~st_r.ce_s2) begin
            st_nxt.sync_pd = 1'b0;
        end else if (cp_event | pulse) begin
            st_nxt.sync_pd = 1'b1;                    // [R6] [R18]
        end
        pd_now = ~st_r.ce_s2                          // [R4]
               | (pd_req & ~pd_sel)                   // [R5]
               | st_nxt.sync_pd;                      // [R6]

        // Fastlock gain bit
        fl_en  = f[`SFL_FL_EN_POS];                   // [R9]
        mode2  = fl_en & f[`SFL_FL_MODE_POS];         // [R10] [R13]
        // Expiry at a count of one, so gain lasts the coded cycles
        expire = mode2 & st_r.gain & pd_cycle
               & (st_r.tmo_cnt == TMO_W'(1));         // [R24]
        if (ld_ab) begin
            // A host write wins over a same-cycle expiry
            st_nxt.gain = lk_r.shift[`SFL_AB_GAIN_POS]; // [R11]
        end else if (expire) begin
            st_nxt.gain = 1'b0;                       // [R12]
        end

        // Timeout counter, held at load state unless it may run
        if (pd_now | pulse | ~mode2 | ~st_nxt.gain
            | ld_ab) begin
            st_nxt.tmo_cnt = tmo_cycles(f[`SFL_TMO_LSB +: 4]); // [R7] [R13]
        end else if (pd_cycle) begin
            st_nxt.tmo_cnt = st_r.tmo_cnt - TMO_W'(1); // [R24] [R12]
        end

        // Registered outputs
        st_nxt.func_o = f;                            // [R22]
        st_nxt.pd_o   = pd_now;
        st_nxt.init_o = pulse;
        // Counters released together, so N and R restart aligned
        st_nxt.cp_o.counter_hold = f[`SFL_CNT_RST_POS] // [R2] [R3]
                                 | pd_now | pulse;   // [R7] [R17]
        st_nxt.cp_o.tmo_load = pd_now | pulse | ~mode2; // [R7] [R13]
        st_nxt.cp_o.tristate = f[`SFL_CP_TRI_POS]     // [R16]
                             | pd_now | pulse;       // [R7] [R17]
        st_nxt.cp_o.lock_det_reset = pd_now;          // [R7]
        st_nxt.cp_o.fastlock = fl_en & st_nxt.gain;   // [R9] [R11]
        st_nxt.cp_o.current = st_nxt.cp_o.fastlock
            ? f[`SFL_CUR2_LSB +: 3]                   // [R14]
            : f[`SFL_CUR1_LSB +: 3];                  // [R14]
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.func <= `SFL_FUNC_RESET;
            st_r.func_o <= `SFL_FUNC_RESET;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign func_word  = st_r.func_o;
    assign powerdown  = st_r.pd_o;
    assign init_pulse = st_r.init_o;
    assign cp_ctl     = st_r.cp_o;
    assign load_out   = st_r.ld_o;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    property p_ce_pd;
        clk_en && !st_r.ce_s2 |=> powerdown;
    endproperty
    a_ce_pd: assert property (p_ce_pd) // [R4]
        else $error("chip enable low did not power down");

    property p_pd_effects;
        powerdown |-> cp_ctl.tristate && cp_ctl.lock_det_reset
                      && cp_ctl.counter_hold && cp_ctl.tmo_load;
    endproperty
    a_pd_effects: assert property (p_pd_effects) // [R7]
        else $error("power-down without its side effects");

    property p_func_load;
        clk_en && stb_rise && sel == `SFL_SEL_FUNC
            |=> st_r.func == $past(lk_r.shift) ##1 !clk_en
                || func_word == $past(lk_r.shift, 2);
    endproperty
    a_func_load: assert property (p_func_load) // [R1]
        else $error("function word not latched");

    property p_cnt_rst;
        clk_en && st_r.func[`SFL_CNT_RST_POS] && !ld_func && !ld_init
            |=> cp_ctl.counter_hold;
    endproperty
    a_cnt_rst: assert property (p_cnt_rst) // [R2]
        else $error("counter reset bit did not hold counters");

    property p_init_pulse;
        clk_en && ld_init |=> init_pulse && cp_ctl.tristate
                              && cp_ctl.counter_hold;
    endproperty
    a_init_pulse: assert property (p_init_pulse) // [R17]
        else $error("init load gave no reset pulse");

    property p_ab_refire;
        clk_en && ld_ab |=> init_pulse == $past(st_r.init_armed);
    endproperty
    a_ab_refire: assert property (p_ab_refire) // [R19]
        else $error("AB load pulse mismatch with armed state");

    property p_current;
        cp_ctl.current == (cp_ctl.fastlock ? func_word[20:18]
                                           : func_word[17:15]);
    endproperty
    a_current: assert property (p_current) // [R14]
        else $error("charge pump current setting wrong");

    property p_async_pd;
        clk_en && st_r.func[`SFL_PD_REQ_POS]
            && !st_r.func[`SFL_PD_SYNC_POS] && !ld_func && !ld_init
            |=> powerdown;
    endproperty
    a_async_pd: assert property (p_async_pd) // [R5]
        else $error("asynchronous power-down not immediate");

    property p_tri_bit;
        clk_en && st_r.func[`SFL_CP_TRI_POS] && !ld_func && !ld_init
            |=> cp_ctl.tristate;
    endproperty
    a_tri_bit: assert property (p_tri_bit) // [R16]
        else $error("three-state bit ignored");

    property p_tmo_idle;
        clk_en && !mode2 && !ld_func && !ld_init
            |=> st_r.tmo_cnt == tmo_cycles(st_r.func[14:11]);
    endproperty
    a_tmo_idle: assert property (p_tmo_idle) // [R13]
        else $error("timeout counter ran outside mode 2");

    property p_expire;
        clk_en && expire && !ld_ab |=> !st_r.gain;
    endproperty
    a_expire: assert property (p_expire) // [R12]
        else $error("gain bit not cleared at timeout");

    property p_keep_func;
        clk_en && !ld_func && !ld_init |=> func_word == $past(func_word);
    endproperty
    a_keep_func: assert property (p_keep_func) // [R22]
        else $error("function word changed without a load");

    property p_fl_gate;
        !func_word[`SFL_FL_EN_POS] |-> !cp_ctl.fastlock;
    endproperty
    a_fl_gate: assert property (p_fl_gate) // [R9]
        else $error("fastlock active while disabled");

    property p_mode1_hold;
        clk_en && fl_en && !mode2 && !ld_ab
            |=> st_r.gain == $past(st_r.gain);
    endproperty
    a_mode1_hold: assert property (p_mode1_hold) // [R11]
        else $error("gain bit moved in mode 1 without a write");

    property p_ab_gain;
        clk_en && ld_ab
            |=> st_r.gain == $past(lk_r.shift[`SFL_AB_GAIN_POS]);
    endproperty
    a_ab_gain: assert property (p_ab_gain) // [R11]
        else $error("gain bit not taken from the AB word");

    property p_sync_wait;
        clk_en && st_r.func[`SFL_PD_REQ_POS] && st_r.func[`SFL_PD_SYNC_POS]
            && st_r.ce_s2 && !st_r.sync_pd && !cp_event && !pulse
            && !ld_func && !ld_init |=> !powerdown;
    endproperty
    a_sync_wait: assert property (p_sync_wait) // [R6]
        else $error("synchronous power-down before a pump event");

    property p_sync_go;
        clk_en && st_r.func[`SFL_PD_REQ_POS] && st_r.func[`SFL_PD_SYNC_POS]
            && st_r.ce_s2 && cp_event && !ld_func && !ld_init
            |=> powerdown;
    endproperty
    a_sync_go: assert property (p_sync_go) // [R6]
        else $error("pump event did not start synchronous power-down");

    property p_pd_load;
        clk_en && powerdown && ld_func |=> func_word == $past(lk_r.shift);
    endproperty
    a_pd_load: assert property (p_pd_load) // [R8]
        else $error("load refused during power-down");

    property p_r_load;
        clk_en && stb_rise && sel == `SFL_SEL_R
            |=> load_out.r_load && load_out.word == $past(lk_r.shift);
    endproperty
    a_r_load: assert property (p_r_load) // [R23]
        else $error("R word not handed on at the strobe");

    property p_pulse_one;
        clk_en && init_pulse |=> !init_pulse;
    endproperty
    a_pulse_one: assert property (p_pulse_one) // [R17]
        else $error("internal reset pulse longer than a cycle");

    property p_tmo_count;
        clk_en && mode2 && st_r.gain && pd_cycle && !pd_now && !pulse
            && !ld_ab && st_r.tmo_cnt > TMO_W'(1)
            |=> st_r.tmo_cnt == $past(st_r.tmo_cnt) - TMO_W'(1);
    endproperty
    a_tmo_count: assert property (p_tmo_count) // [R24]
        else $error("timeout counter missed a phase detector cycle");

    property p_tmo_start;
        clk_en && ld_ab
            |=> st_r.tmo_cnt == tmo_cycles(st_r.func[`SFL_TMO_LSB +: 4]);
    endproperty
    a_tmo_start: assert property (p_tmo_start) // [R24]
        else $error("timeout counter not loaded by the AB word");

    property p_ce_effects;
        clk_en && !st_r.ce_s2 |=> cp_ctl.tristate && cp_ctl.counter_hold
                                  && cp_ctl.lock_det_reset;
    endproperty
    a_ce_effects: assert property (p_ce_effects) // [R7]
        else $error("chip enable low left the pump or counters running");

    property p_tri_free;
        clk_en && !st_r.func[`SFL_CP_TRI_POS] && !pd_now && !pulse
            && !ld_func && !ld_init |=> !cp_ctl.tristate;
    endproperty
    a_tri_free: assert property (p_tri_free) // [R16]
        else $error("charge pump floated with the bit clear");

    property p_cnt_free;
        clk_en && !st_r.func[`SFL_CNT_RST_POS] && !pd_now && !pulse
            && !ld_func && !ld_init |=> !cp_ctl.counter_hold;
    endproperty
    a_cnt_free: assert property (p_cnt_free) // [R2]
        else $error("counters held with the reset bit clear");

    // ************************************************************
    // Cover points
    // ************************************************************
    c_init:   cover property (clk_en && ld_init);
    c_ab_re:  cover property (clk_en && ld_ab && st_r.init_armed);
    c_expire: cover property (clk_en && expire);
    c_sync:   cover property (clk_en && !st_r.sync_pd && st_nxt.sync_pd);
    c_ce_low: cover property (clk_en && !st_r.ce_s2);

endmodule

// [verification/sfl_host.sv]
// Host model that writes 24-bit words over the three-wire link.
// Assumes the caller waits for send() to return before the next word.
`timescale 1ns/1ps

module sfl_host (
    input  logic clock,
    output logic link_clk,
    output logic ser_data,
    output logic latch_load_strobe
);
    // ****************************************
    // Word transmit
    // ****************************************
    initial begin
        link_clk          = 1'b0;
        ser_data          = 1'b0;
        latch_load_strobe = 1'b0;
    end

    // Clock only inside a frame, 48 ns period, MSB first
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i];
            #24 link_clk = 1'b1;
            #24 link_clk = 1'b0;
        end
        // Released line shows the inverse, never a stale bit
        ser_data = ~ser_data;
        // Strobe held 7 main clocks, then at least 4 low
        #5 latch_load_strobe = 1'b1;
        #700 latch_load_strobe = 1'b0;
        #400;
        // Return on a falling edge, so checks never meet a launch edge
        @(negedge clock);
    endtask
endmodule

// [verification/sfl_ctrl_test.sv]
// Self-checking bench for the synthesizer latch control.
// Assumes sfl_host on the link; all checks are made at the ports.
`timescale 1ns/1ps
`include "sfl_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module sfl_ctrl_test;
    import sfl_pkg::*;

    logic        clock, sys_rst, chip_enable, cp_event, pd_cycle;
    logic        link_clk, ser_data, strobe, powerdown, init_pulse;
    logic [23:0] func_word, f, a;
    sfl_cp_ctl_s cp_ctl;
    sfl_load_s   load_out;
    int          n_errors, cmp_count, cycles, n_init, n;

    // ****************************************
    // Design, host and clock
    // ****************************************
    sfl_ctrl #(.TMO_W(6)) DUT (
        .clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
        .link_clk(link_clk), .ser_data(ser_data),
        .latch_load_strobe(strobe), .chip_enable(chip_enable),
        .cp_event(cp_event), .pd_cycle(pd_cycle),
        .func_word(func_word), .powerdown(powerdown),
        .init_pulse(init_pulse), .cp_ctl(cp_ctl), .load_out(load_out)
    );
    sfl_host u_host (
        .clock(clock), .link_clk(link_clk), .ser_data(ser_data),
        .latch_load_strobe(strobe)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (init_pulse === 1'b1) n_init++;
        if (cycles == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    // Prescaler kept at 16/17 so its output stays legal
    function automatic logic [23:0] fw(logic [31:0] r, logic [1:0] s);
        return {2'h1, r[21:2], s};
    endfunction

    function automatic logic exp_pd(logic [23:0] w);
        return w[`SFL_PD_REQ_POS] & ~w[`SFL_PD_SYNC_POS];
    endfunction

    task automatic pulse_pd(int k);
        repeat (k) begin
            @(negedge clock) pd_cycle = 1'b1;
            @(negedge clock) pd_cycle = 1'b0;
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(24354));
        {cp_event, pd_cycle, n_errors, cmp_count, cycles, n_init} = '0;
        chip_enable = 1'b1;
        sys_rst     = 1'b1;
        repeat (16) @(negedge clock);
        `CHK(func_word, 24'h000000)
        sys_rst = 1'b0;
        repeat (6) @(negedge clock);
        `CHK(powerdown, 1'b0)
        repeat (8) begin
            f = fw($urandom, `SFL_SEL_FUNC);
            f[`SFL_FL_EN_POS] = 1'b0;
            u_host.send(f);
            `CHK(func_word, f)
            `CHK(cp_ctl.counter_hold, f[2] | exp_pd(f))
            `CHK(powerdown, exp_pd(f))
            `CHK(cp_ctl.current, f[17:15])
            if (!f[2]) `CHK(cp_ctl.tristate, f[8] | exp_pd(f))
        end
        f[3:2] = 2'h0;
        f[21]  = 1'b1;
        u_host.send(f);
        f[3] = 1'b1;
        u_host.send(f);
        `CHK(powerdown, 1'b0)
        @(negedge clock) cp_event = 1'b1;
        @(negedge clock) cp_event = 1'b0;
        repeat (2) @(negedge clock);
        `CHK(powerdown, 1'b1)
        f[3] = 1'b0;
        u_host.send(f);
        @(negedge clock) chip_enable = 1'b0;
        repeat (5) @(negedge clock);
        `CHK(powerdown, 1'b1)
        `CHK(cp_ctl.lock_det_reset & cp_ctl.tmo_load, 1'b1)
        `CHK(cp_ctl.tristate & cp_ctl.counter_hold, 1'b1)
        f[10:9] = 2'h0;
        u_host.send(f);
        `CHK(func_word, f)
        @(negedge clock) chip_enable = 1'b1;
        repeat (5) @(negedge clock);
        `CHK(powerdown, 1'b0)
        `CHK(func_word, f)
        f[`SFL_PD_REQ_POS] = 1'b1;
        f[1:0] = `SFL_SEL_INIT;
        n_init = 0;
        u_host.send(f);
        `CHK(n_init, 1)
        `CHK(func_word, f)
        `CHK(powerdown, 1'b1)
        f[3] = 1'b0;
        f[1:0] = `SFL_SEL_FUNC;
        u_host.send(f);
        u_host.send(fw($urandom, `SFL_SEL_R));
        `CHK(n_init, 1)
        for (int i = 0; i < 2; i++) begin
            a = fw($urandom, `SFL_SEL_AB);
            a[`SFL_AB_GAIN_POS] = 1'b0;
            u_host.send(a);
            `CHK(n_init, 2)
        end
        for (int m = 0; m < 3; m++) begin
            f = fw($urandom, `SFL_SEL_FUNC);
            f[3:2] = 2'h0;
            f[`SFL_FL_EN_POS]   = (m != 0);
            f[`SFL_FL_MODE_POS] = (m == 2);
            u_host.send(f);
            a[`SFL_AB_GAIN_POS] = 1'b1;
            u_host.send(a);
            `CHK(cp_ctl.fastlock, m != 0)
            `CHK(cp_ctl.current, m ? f[20:18] : f[17:15])
            n = 4 * f[14:11] + 3;
            pulse_pd(n - 1);
            `CHK(cp_ctl.fastlock, m != 0)
            pulse_pd(1);
            `CHK(cp_ctl.fastlock, m == 1)
            a[`SFL_AB_GAIN_POS] = 1'b0;
            u_host.send(a);
            `CHK(cp_ctl.fastlock, 1'b0)
        end
        report_and_stop();
    end
endmodule
